// [logic/irq_init_pkg.sv]
// Constants, types and helpers shared by the cascaded interrupt controller pair
// ----------------------------------------------------------------------------
// Functional notes
// - A base-address write with bit 4 set is word one and starts initialization.
// - Exactly three writes to base plus one follow, taken as words two to four.
// - Word one bits 2 and 3 ignored; trigger type comes from a per-line input.
// - After all four words, base writes with bit 4 clear are control words two/three.
// - Bit 4 set in any base write restarts initialization from any state.
// - Word two bits 7:3 hold vector base; level code latched on first acknowledge fills 2:0.
// - Low vector bits are the binary level index; slave codes mean requests 8-15.
// - Slave word three holds identity 010b, compared with the master's broadcast code.
// - Word four bit 1 selects explicit or automatic end of interrupt.
// - Word four bit 4 enables special fully nested priority.
// - Plus-one writes only after initialization completes load the mask; master line two blocks slave.
// ----------------------------------------------------------------------------
package irq_init_pkg;

  // --------------------------------------------------------------------------
  // I/O map
  // --------------------------------------------------------------------------
  localparam logic [15:0] MASTER_BASE_ADDR = 16'h0020;
  localparam logic [15:0] MASTER_PLUS_ADDR = 16'h0021;
  localparam logic [15:0] SLAVE_BASE_ADDR  = 16'h00a0;
  localparam logic [15:0] SLAVE_PLUS_ADDR  = 16'h00a1;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int INIT_SEL_BIT    = 4;
  localparam int CTRL3_SEL_BIT   = 3;
  localparam int AUTO_EOI_BIT    = 1;
  localparam int NESTED_BIT      = 4;
  localparam int VEC_BASE_LSB    = 3;
  localparam int EOI_CODE_LSB    = 5;
  localparam int READ_SEL_BIT    = 0;
  localparam int READ_EN_BIT     = 1;
  localparam logic [2:0] EOI_NONSPEC = 3'h1;
  localparam logic [2:0] EOI_SPEC    = 3'h3;
  localparam logic [7:0] MASK_RESET  = 8'h00;

  typedef enum logic [2:0] {
    ST_UNINIT,
    ST_WORD_TWO,
    ST_WORD_THREE,
    ST_WORD_FOUR,
    ST_READY
  } init_state_t;

  // Lowest index wins: fixed priority with line 0 highest
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h7;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = i[2:0];
      end
    end
    return idx;
  endfunction

endpackage

// [logic/irq_unit_if.sv]
// Signals between the top decoder and one interrupt unit
`timescale 1ns/1ps
interface irq_unit_if;
  logic       wr_base;
  logic       wr_plus;
  logic [7:0] wdata;
  logic [7:0] irq;
  logic [7:0] level_sel;
  logic       ack1;
  logic       ack2;
  logic       is_slave;
  logic [2:0] cas_in;
  logic       cas_in_sel;
  logic       int_req;
  logic       vec_drive;
  logic [7:0] vector;
  logic [2:0] cas_out;
  logic       cas_sel;
  logic [7:0] rd_base;
  logic [7:0] rd_plus;

  modport unit (
    input  wr_base, wr_plus, wdata, irq, level_sel, ack1, ack2, is_slave,
    input  cas_in, cas_in_sel,
    output int_req, vec_drive, vector, cas_out, cas_sel, rd_base, rd_plus
  );
  modport top (
    output wr_base, wr_plus, wdata, irq, level_sel, ack1, ack2, is_slave,
    output cas_in, cas_in_sel,
    input  int_req, vec_drive, vector, cas_out, cas_sel, rd_base, rd_plus
  );
endinterface

// [logic/irq_unit.sv]
// One interrupt unit: init sequence, request, in-service and acknowledge logic
`timescale 1ns/1ps
module irq_unit
  import irq_init_pkg::*;
#(
  parameter int LINES = 8
) (
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  // Decoder side
  irq_unit_if.unit   u
);

  // Priority search and three-bit level code assume exactly eight lines
  if (LINES != 8) begin : g_lines_check
    $error("irq_unit serves exactly eight request lines");
  end

  init_state_t st_reg;
  logic [7:0]  irr_reg;
  logic [7:0]  isr_reg;
  logic [7:0]  prev_reg;
  logic [7:0]  mask_reg;
  logic [4:0]  base_reg;
  logic [7:0]  casc_reg;
  logic        auto_eoi_reg;
  logic        nested_reg;
  logic [1:0]  read_sel_reg;
  logic [2:0]  lvl_reg;
  logic        respond_reg;

  wire        ready     = (st_reg == ST_READY);
  wire        init_wr   = u.wr_base & u.wdata[INIT_SEL_BIT];
  wire        ctrl_wr   = u.wr_base & ~u.wdata[INIT_SEL_BIT] & ready;
  wire        ctl2_wr   = ctrl_wr & ~u.wdata[CTRL3_SEL_BIT];
  wire        ctl3_wr   = ctrl_wr & u.wdata[CTRL3_SEL_BIT];
  wire [2:0]  eoi_code  = u.wdata[EOI_CODE_LSB +: 3];
  wire [7:0]  pend      = irr_reg & ~mask_reg;
  wire [2:0]  pidx      = first_set(pend);
  wire [2:0]  iidx      = first_set(isr_reg);
  wire        isr_any   = |isr_reg;
  // Nested mode lets a cascade line re-enter at its own level
  wire        same_ok   = nested_reg & casc_reg[pidx] & ~u.is_slave;
  wire        beats_isr = ~isr_any | (pidx < iidx) | ((pidx == iidx) & same_ok);
  wire        req       = ready & (|pend) & beats_isr;
  wire        is_casc   = ~u.is_slave & casc_reg[pidx];
  wire        slave_hit = u.is_slave & u.cas_in_sel & (u.cas_in == casc_reg[2:0]);
  wire        take      = u.ack1 & req & (~u.is_slave | slave_hit);
  wire [7:0]  take_bit  = take ? (8'h01 << pidx) : 8'h00;
  wire [7:0]  edge_set  = u.irq & ~prev_reg & ~u.level_sel;
  wire [7:0]  irr_edge  = (irr_reg & ~take_bit) | edge_set;               // Set beats clear
  wire [7:0]  irr_next  = init_wr ? 8'h00 : ((irr_edge & ~u.level_sel) | (u.irq & u.level_sel));
  wire [2:0]  eoi_lvl   = (eoi_code == EOI_SPEC) ? u.wdata[2:0] : iidx;
  wire        eoi_hit   = ctl2_wr & ((eoi_code == EOI_NONSPEC) | (eoi_code == EOI_SPEC));
  wire [7:0]  eoi_bit   = eoi_hit ? (8'h01 << eoi_lvl) : 8'h00;
  wire [7:0]  aeoi_bit  = (u.ack2 & auto_eoi_reg & ready) ? (8'h01 << lvl_reg) : 8'h00;
  wire [7:0]  isr_next  = init_wr ? 8'h00 : ((isr_reg & ~eoi_bit & ~aeoi_bit) | take_bit);

  assign u.int_req   = req;
  assign u.cas_out   = pidx;
  assign u.cas_sel   = req & is_casc;
  assign u.vec_drive = u.ack2 & respond_reg;
  assign u.vector    = {base_reg, lvl_reg};
  assign u.rd_plus   = mask_reg;
  assign u.rd_base   = read_sel_reg[READ_SEL_BIT] ? isr_reg : irr_reg;

  // --------------------------------------------------------------------------
  // Initialization sequence
  // --------------------------------------------------------------------------
  // Word one bits 2 and 3 are never looked at: trigger type is per line input
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= ST_UNINIT;
    end else if (init_wr) begin
      st_reg <= ST_WORD_TWO;
    end else if (u.wr_plus) begin
      case (st_reg)
        ST_WORD_TWO:   st_reg <= ST_WORD_THREE;
        ST_WORD_THREE: st_reg <= ST_WORD_FOUR;
        ST_WORD_FOUR:  st_reg <= ST_READY;
        default:       st_reg <= st_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      base_reg     <= '0;
      casc_reg     <= '0;
      auto_eoi_reg <= 1'b0;
      nested_reg   <= 1'b0;
    end else if (u.wr_plus) begin
      if (st_reg == ST_WORD_TWO) begin
        base_reg <= u.wdata[7:VEC_BASE_LSB];
      end
      if (st_reg == ST_WORD_THREE) begin
        casc_reg <= u.wdata;
      end
      if (st_reg == ST_WORD_FOUR) begin
        auto_eoi_reg <= u.wdata[AUTO_EOI_BIT];
        nested_reg   <= u.wdata[NESTED_BIT];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mask, read select, request and service state
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mask_reg     <= MASK_RESET;
      read_sel_reg <= '0;
    end else begin
      if (u.wr_plus & ready) begin
        mask_reg <= u.wdata;
      end
      if (ctl3_wr & u.wdata[READ_EN_BIT]) begin
        read_sel_reg <= u.wdata[1:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irr_reg  <= '0;
      isr_reg  <= '0;
      prev_reg <= '0;
    end else begin
      irr_reg  <= irr_next;
      isr_reg  <= isr_next;
      prev_reg <= u.irq;
    end
  end

  // --------------------------------------------------------------------------
  // Acknowledge capture
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_reg     <= '0;
      respond_reg <= 1'b0;
    end else if (init_wr) begin
      respond_reg <= 1'b0;
    end else if (u.ack1) begin
      lvl_reg     <= pidx;
      respond_reg <= take & ~is_casc;
    end
  end

endmodule

// [logic/cascaded_irq_ctrl_init.sv]
// Top of the cascaded interrupt controller pair: I/O decode, sync, vector out
`timescale 1ns/1ps
module cascaded_irq_ctrl_init
  import irq_init_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Processor I/O port
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [15:0] i_io_addr,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  // Request pins and per-line trigger type (1 = level)
  input  wire logic [15:0] i_irq,
  input  wire logic [15:0] i_trigger_type_select,
  // Acknowledge and vector
  input  wire logic        i_interrupt_acknowledge_n,
  output logic             o_int,
  output logic      [7:0]  o_vec_data,
  output logic             o_vec_valid
);

  localparam int MASTER      = 0;
  localparam int SLAVE       = 1;
  localparam int CASC_LINE   = 2;

  irq_unit_if uif [2] ();

  logic [15:0] irq_meta_reg;
  logic [15:0] irq_sync_reg;
  logic        ack_meta_reg;
  logic        ack_sync_reg;
  logic        ack_prev_reg;
  logic        ack_second_reg;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_meta_reg <= '0;
      irq_sync_reg <= '0;
      ack_meta_reg <= 1'b1;
      ack_sync_reg <= 1'b1;
      ack_prev_reg <= 1'b1;
    end else begin
      irq_meta_reg <= i_irq;
      irq_sync_reg <= irq_meta_reg;
      ack_meta_reg <= i_interrupt_acknowledge_n;
      ack_sync_reg <= ack_meta_reg;
      ack_prev_reg <= ack_sync_reg;
    end
  end

  // Two acknowledge pulses per interrupt; the second carries the vector
  wire ack_fall = ack_prev_reg & ~ack_sync_reg;
  wire ack1     = ack_fall & ~ack_second_reg;
  wire ack2     = ack_fall & ack_second_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_second_reg <= 1'b0;
    end else if (ack_fall) begin
      ack_second_reg <= ~ack_second_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire m_base = (i_io_addr == MASTER_BASE_ADDR);
  wire m_plus = (i_io_addr == MASTER_PLUS_ADDR);
  wire s_base = (i_io_addr == SLAVE_BASE_ADDR);
  wire s_plus = (i_io_addr == SLAVE_PLUS_ADDR);

  assign uif[MASTER].wr_base    = i_io_wr & m_base;
  assign uif[MASTER].wr_plus    = i_io_wr & m_plus;
  assign uif[SLAVE].wr_base     = i_io_wr & s_base;
  assign uif[SLAVE].wr_plus     = i_io_wr & s_plus;
  assign uif[MASTER].wdata      = i_io_wdata;
  assign uif[SLAVE].wdata       = i_io_wdata;

  // Slave output replaces the master's line two; the master mask then gates it
  assign uif[MASTER].irq        = {irq_sync_reg[7:CASC_LINE+1], uif[SLAVE].int_req,
                                   irq_sync_reg[CASC_LINE-1:0]};
  assign uif[SLAVE].irq         = irq_sync_reg[15:8];
  assign uif[MASTER].level_sel  = {i_trigger_type_select[7:CASC_LINE+1], 1'b1,
                                   i_trigger_type_select[CASC_LINE-1:0]};
  assign uif[SLAVE].level_sel   = i_trigger_type_select[15:8];
  assign uif[MASTER].ack1       = ack1;
  assign uif[MASTER].ack2       = ack2;
  assign uif[SLAVE].ack1        = ack1;
  assign uif[SLAVE].ack2        = ack2;
  assign uif[MASTER].is_slave   = 1'b0;
  assign uif[SLAVE].is_slave    = 1'b1;
  assign uif[MASTER].cas_in     = 3'h0;
  assign uif[MASTER].cas_in_sel = 1'b0;
  assign uif[SLAVE].cas_in      = uif[MASTER].cas_out;
  assign uif[SLAVE].cas_in_sel  = uif[MASTER].cas_sel;

  irq_unit #(.LINES(8)) u_master (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .u      (uif[MASTER])
  );

  irq_unit #(.LINES(8)) u_slave (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .u      (uif[SLAVE])
  );

  // --------------------------------------------------------------------------
  // Read data and vector output
  // --------------------------------------------------------------------------
  wire [7:0] rd_mux = m_base ? uif[MASTER].rd_base :
                      m_plus ? uif[MASTER].rd_plus :
                      s_base ? uif[SLAVE].rd_base  :
                      s_plus ? uif[SLAVE].rd_plus  : 8'h00;
  wire       vec_any = uif[MASTER].vec_drive | uif[SLAVE].vec_drive;
  wire [7:0] vec_mux = uif[SLAVE].vec_drive ? uif[SLAVE].vector : uif[MASTER].vector;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata  <= 8'h00;
      o_vec_data  <= 8'h00;
      o_vec_valid <= 1'b0;
      o_int       <= 1'b0;
    end else begin
      if (i_io_rd) begin
        o_io_rdata <= rd_mux;
      end
      if (vec_any) begin
        o_vec_data <= vec_mux;
      end
      o_vec_valid <= vec_any;
      o_int       <= uif[MASTER].int_req;
    end
  end

endmodule

// [tb/irq_init_props.sv]
// Port-level assertions for the cascaded interrupt controller pair
`timescale 1ns/1ps
module irq_init_props
  import irq_init_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // Watched ports
  input wire logic        i_io_wr,
  input wire logic        i_io_rd,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0]  i_io_wdata,
  input wire logic [7:0]  o_io_rdata,
  input wire logic [15:0] i_irq,
  input wire logic [15:0] i_trigger_type_select,
  input wire logic        i_interrupt_acknowledge_n,
  input wire logic        o_int,
  input wire logic [7:0]  o_vec_data,
  input wire logic        o_vec_valid
);
  // --------------------------------------------------------------
  // Master init step, mask and acknowledge age
  // --------------------------------------------------------------
  logic [2:0] step_reg;
  logic [7:0] mask_reg;
  logic [3:0] since_reg;
  logic       ack_d_reg;
  wire        plus_wr  = i_io_wr && i_io_addr == MASTER_PLUS_ADDR;
  wire        word_one = i_io_wr && i_io_addr == MASTER_BASE_ADDR && i_io_wdata[INIT_SEL_BIT];
  wire        mapped   = i_io_addr == MASTER_BASE_ADDR || i_io_addr == MASTER_PLUS_ADDR ||
                         i_io_addr == SLAVE_BASE_ADDR || i_io_addr == SLAVE_PLUS_ADDR;
  wire        in_init  = step_reg != 3'h0 && step_reg != 3'h4;
  wire [2:0]  step_next  = word_one ? 3'h1 : (plus_wr && in_init) ? step_reg + 3'h1 : step_reg;
  wire [7:0]  mask_next  = (plus_wr && step_reg == 3'h4) ? i_io_wdata : mask_reg;
  wire        ack_fall   = ack_d_reg && !i_interrupt_acknowledge_n;
  // Saturates so a stale vector can never look fresh
  wire [3:0]  since_next = ack_fall ? 4'h0 : (since_reg == 4'hf) ? 4'hf : since_reg + 4'h1;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      step_reg  <= 3'h0;
      mask_reg  <= MASK_RESET;
      since_reg <= 4'hf;
      ack_d_reg <= 1'b1;
    end else begin
      step_reg  <= step_next;
      mask_reg  <= mask_next;
      since_reg <= since_next;
      ack_d_reg <= i_interrupt_acknowledge_n;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_VEC_PULSE: assert property (o_vec_valid |=> !o_vec_valid)
    else $error("vector valid wider than one cycle");
  AST_VEC_HOLD: assert property (!o_vec_valid |-> $stable(o_vec_data))
    else $error("vector changed without valid");
  AST_VEC_AFTER_ACK: assert property (o_vec_valid |-> since_reg <= 4'h6)
    else $error("vector without recent acknowledge");
  AST_MASK_READ: assert property (i_io_rd && i_io_addr == MASTER_PLUS_ADDR |=>
    o_io_rdata == $past(mask_reg)) else $error("mask readback wrong");
  AST_RD_HOLD: assert property (!i_io_rd |=> $stable(o_io_rdata))
    else $error("read data moved without read");
  AST_UNMAPPED: assert property (i_io_rd && !mapped |=> o_io_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_INIT_QUIET: assert property (word_one |-> ##2 !o_int)
    else $error("request survived word one");
  AST_MASKED_QUIET: assert property (mask_reg == 8'hff && $past(mask_reg, 2) == 8'hff
    |-> !o_int) else $error("request while fully masked");

  COV_WORD_ONE: cover property (word_one);
  COV_VECTOR: cover property (o_vec_valid);
  COV_TOP_CODE: cover property (o_vec_valid && o_vec_data[2:0] == 3'h7);
endmodule

bind cascaded_irq_ctrl_init irq_init_props i_irq_init_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
  .i_irq(i_irq), .i_trigger_type_select(i_trigger_type_select),
  .i_interrupt_acknowledge_n(i_interrupt_acknowledge_n), .o_int(o_int),
  .o_vec_data(o_vec_data), .o_vec_valid(o_vec_valid)
);

// [tb/host_ack_model.sv]
// Host model issuing acknowledge cycle pairs
`timescale 1ns/1ps
module host_ack_model (
  // Clock and command
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [3:0] i_width,
  // Acknowledge pin and state
  output logic            o_ack_n,
  output logic            o_busy
);
  initial begin
    o_ack_n = 1'b1;
    o_busy  = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        // Two low pulses of i_width cycles each per vector, pin idles high
        repeat (2) begin
          o_ack_n <= 1'b0;
          repeat (i_width) @(posedge i_clk);
          o_ack_n <= 1'b1;
          repeat (i_width) @(posedge i_clk);
        end
        o_busy <= 1'b0;
      end
    end
  end
endmodule

// [tb/cascaded_irq_ctrl_init_bench.sv]
// Self-checking bench for the cascaded interrupt controller pair
`timescale 1ns/1ps
module cascaded_irq_ctrl_init_bench;
  logic        i_clk, i_rstn, i_io_wr, i_io_rd, o_int, o_vec_valid, ack_n, go, busy;
  logic [15:0] i_io_addr, i_irq, i_trg;
  logic [7:0]  i_io_wdata, o_io_rdata, o_vec_data, vec_seen;
  logic [3:0]  width;
  int          num_errors, n_checks, vec_cnt;

  cascaded_irq_ctrl_init i_cascaded_irq_ctrl_init (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
    .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_irq(i_irq), .i_trigger_type_select(i_trg), .i_interrupt_acknowledge_n(ack_n),
    .o_int(o_int), .o_vec_data(o_vec_data), .o_vec_valid(o_vec_valid));
  host_ack_model i_host_ack_model (
    .i_clk(i_clk), .i_go(go), .i_width(width), .o_ack_n(ack_n), .o_busy(busy));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (o_vec_valid === 1'b1) begin
      vec_seen <= o_vec_data;
      vec_cnt  <= vec_cnt + 1;
    end
  end

  // --------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_io_wr    <= 1'b1;
    i_io_addr  <= a;
    i_io_wdata <= d;
    @(posedge i_clk);
    i_io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_io_rd   <= 1'b1;
    i_io_addr <= a;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    #1;
    check(o_io_rdata, exp);
  endtask
  task automatic wait_int(input logic lvl);
    int k;
    k = 0;
    #1;
    while (o_int !== lvl && k < 40) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check({7'h0, o_int}, {7'h0, lvl});
    if (o_int !== lvl) give_verdict();
  endtask
  // Host may answer promptly or slowly
  task automatic ack(input logic [7:0] exp, input logic [3:0] w);
    int c0;
    int k;
    c0 = vec_cnt;
    @(posedge i_clk);
    width <= w;
    go    <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    k = 0;
    while (busy && k < 100) begin
      @(posedge i_clk);
      k++;
    end
    #1;
    check(8'(vec_cnt - c0), 8'h01);
    check(vec_seen, exp);
  endtask

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    i_rstn     = 1'b0;
    i_io_wr    = 1'b0;
    i_io_rd    = 1'b0;
    i_io_addr  = 16'h0000;
    i_io_wdata = 8'h00;
    i_irq      = 16'h0000;
    i_trg      = 16'h0000;
    go         = 1'b0;
    width      = 4'h4;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(16'h0021, 8'h00);
    rd(16'h0022, 8'h00);
    wr(16'h0020, 8'h11);
    wr(16'h0021, 8'h08);
    wr(16'h0021, 8'h04);
    wr(16'h0021, 8'h01);
    wr(16'h00a0, 8'h11);
    wr(16'h00a1, 8'h70);
    wr(16'h00a1, 8'h02);
    wr(16'h00a1, 8'h03);
    rd(16'h0021, 8'h00);
    rd(16'h00a1, 8'h00);
    wr(16'h0021, 8'hff);
    rd(16'h0021, 8'hff);
    wr(16'h0021, 8'h00);
    wr(16'h0020, 8'h0b);
    wr(16'h00a0, 8'h0b);
    for (int i = 0; i < 8; i++) begin
      if (i != 2) begin
        i_irq[i] <= 1'b1;
        wait_int(1'b1);
        ack(8'h08 | 8'(i), 4'h4);
        rd(16'h0020, 8'h01 << i);
        wr(16'h0020, 8'h20);
        rd(16'h0020, 8'h00);
      end
      i_irq[8 + i] <= 1'b1;
      wait_int(1'b1);
      ack(8'h70 | 8'(i), 4'hc);
      rd(16'h00a0, 8'h00);
      wr(16'h0020, 8'h20);
    end
    i_irq <= 16'h0000;
    wr(16'h0021, 8'h04);
    i_irq[9] <= 1'b1;
    repeat (12) @(posedge i_clk);
    #1;
    check({7'h0, o_int}, 8'h00);
    wr(16'h0021, 8'h80);
    wait_int(1'b1);
    ack(8'h71, 4'h4);
    wr(16'h0020, 8'h20);
    i_irq[5] <= 1'b1;
    wait_int(1'b1);
    wr(16'h0020, 8'h1d);
    wait_int(1'b0);
    wr(16'h0021, 8'h08);
    wr(16'h0021, 8'h04);
    wr(16'h0021, 8'h13);
    repeat (8) @(posedge i_clk);
    #1;
    check({7'h0, o_int}, 8'h00);
    rd(16'h0021, 8'h80);
    i_irq[5] <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_irq[5] <= 1'b1;
    wait_int(1'b1);
    ack(8'h0d, 4'hc);
    give_verdict();
  end
endmodule
